//--- hdl/oled_cmd_pkg.sv
// Shared constants, opcodes and types of the display command decoder
package oled_cmd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W         = 5;
  localparam logic [4:0] OFS_CMD        = 5'h00;
  localparam logic [4:0] OFS_ADDRESSING = 5'h04;
  localparam logic [4:0] OFS_WINDOW     = 5'h08;
  localparam logic [4:0] OFS_DISPLAY    = 5'h0C;
  localparam logic [4:0] OFS_TIMING     = 5'h10;

  // ----------------------------------------------------------------
  // Addressing modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_HORIZ   = 2'h0;
  localparam logic [1:0] MODE_VERT    = 2'h1;
  localparam logic [1:0] MODE_PAGE    = 2'h2;
  localparam logic [1:0] MODE_INVALID = 2'h3;

  // ----------------------------------------------------------------
  // Opcodes with parameters, the no-operation opcode, and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ADDR_MODE  = 8'h20;
  localparam logic [7:0] OP_COL_WIN    = 8'h21;
  localparam logic [7:0] OP_PAGE_WIN   = 8'h22;
  localparam logic [7:0] OP_CONTRAST   = 8'h81;
  localparam logic [7:0] OP_RATIO      = 8'hA8;
  localparam logic [7:0] OP_IREF       = 8'hAD;
  localparam logic [7:0] OP_OFFSET     = 8'hD3;
  localparam logic [7:0] OP_CLOCK      = 8'hD5;
  localparam logic [7:0] OP_PRECHARGE  = 8'hD9;
  localparam logic [7:0] OP_ROW_PINS   = 8'hDA;
  localparam logic [7:0] OP_DESELECT   = 8'hDB;
  localparam logic [7:0] OP_NO_OP      = 8'hE3;
  localparam logic [5:0] RATIO_MIN     = 6'h0F;
  localparam logic [7:0] CONTRAST_MIN  = 8'h01;

  // ----------------------------------------------------------------
  // Configuration state and its reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] addr_mode;
    logic [6:0] page_col;
    logic [2:0] page_sel;
    logic [5:0] start_line;
    logic [6:0] col_start;
    logic [6:0] col_end;
    logic [2:0] page_start;
    logic [2:0] page_end;
    logic [7:0] contrast;
    logic       col_mirror;
    logic       entire_on;
    logic       inverse;
    logic       display_on;
    logic       row_scan_down;
    logic       alt_row_pins;
    logic       row_lr_remap;
    logic       iref_internal;
    logic       iref_high;
    logic [1:0] deselect_level;
    logic [5:0] multiplex_ratio;
    logic [5:0] row_offset;
    logic [3:0] clock_divide;
    logic [3:0] oscillator_frequency;
    logic [3:0] phase1;
    logic [3:0] phase2;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{
    addr_mode: MODE_PAGE, page_col: 7'h00, page_sel: 3'h0,
    start_line: 6'h00, col_start: 7'h00, col_end: 7'h7F,
    page_start: 3'h0, page_end: 3'h7, contrast: 8'h7F,
    col_mirror: 1'b0, entire_on: 1'b0, inverse: 1'b0,
    display_on: 1'b0, row_scan_down: 1'b0, alt_row_pins: 1'b1,
    row_lr_remap: 1'b0, iref_internal: 1'b0, iref_high: 1'b0,
    deselect_level: 2'h2, multiplex_ratio: 6'h3F, row_offset: 6'h00,
    clock_divide: 4'h0, oscillator_frequency: 4'h8,
    phase1: 4'h2, phase2: 4'h2};

  typedef enum logic [1:0] {ST_OPCODE, ST_PARAM_A, ST_PARAM_B} dec_state_e;

endpackage

//--- hdl/oled_command_decoder.sv
// Command decoder for the display configuration command set, APB slave
//
// Operation
// - 00h-0Fh set page-mode column low nibble
// - 10h-17h set page-mode column high bits
// - 20h plus byte selects addressing mode
// - 21h sets column start and end
// - 22h sets page start and end
// - 40h-7Fh set display start line
// - 81h plus byte sets contrast level
// - A0h/A1h select column mirroring
// - A4h/A5h follow memory or all on
// - A6h/A7h normal or inverse polarity
// - A8h sets multiplex ratio N+1
// - ADh selects current reference and level
// - AEh display off, AFh display on
// - B0h-B7h set page-mode page address
// - C0h/C8h choose row scan direction
// - D3h sets vertical row shift
// - D5h sets clock divide and oscillator
// - D9h sets both pre-charge phase periods
// - DAh sets row pin configuration
// - DBh sets row deselect level
// - E3h is accepted and changes nothing
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module oled_command_decoder
  import oled_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Configuration toward the display timing logic
  output cfg_s             CFG
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] offset;
  logic              mapped;
  logic              access;
  logic              cmd_valid;
  logic [7:0]        cmd_byte;

  assign offset = PADDR[ADDR_W-1:0];
  assign access = PSEL && PENABLE;

  always_comb begin
    mapped = (PADDR[31:ADDR_W] == '0);
    unique case (offset)
      OFS_CMD, OFS_ADDRESSING, OFS_WINDOW, OFS_DISPLAY, OFS_TIMING: begin
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Only the command port is writable; a write without the low lane carries no byte
  assign cmd_valid = access && PWRITE && mapped && (offset == OFS_CMD) && PSTRB[0];
  assign cmd_byte  = PWDATA[7:0];

  // Zero wait states: every access completes in its first access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = access && (!mapped || (PWRITE && offset != OFS_CMD));

  // ----------------------------------------------------------------
  // Parameter collection
  // ----------------------------------------------------------------
  dec_state_e state;
  logic [7:0] held_op;
  logic [7:0] param_a;

  function automatic logic takes_param(input logic [7:0] op);
    unique case (op)
      OP_ADDR_MODE, OP_COL_WIN, OP_PAGE_WIN, OP_CONTRAST, OP_RATIO, OP_IREF,
      OP_OFFSET, OP_CLOCK, OP_PRECHARGE, OP_ROW_PINS, OP_DESELECT: takes_param = 1'b1;
      default: takes_param = 1'b0;
    endcase
  endfunction

  function automatic logic takes_two(input logic [7:0] op);
    takes_two = (op == OP_COL_WIN) || (op == OP_PAGE_WIN);
  endfunction

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      state   <= ST_OPCODE;
      held_op <= 8'h00;
      param_a <= 8'h00;
    end else if (cmd_valid) begin
      unique case (state)
        ST_OPCODE: begin
          held_op <= cmd_byte;
          if (takes_param(cmd_byte)) begin
            state <= ST_PARAM_A;
          end
        end
        ST_PARAM_A: begin
          param_a <= cmd_byte;
          state   <= takes_two(held_op) ? ST_PARAM_B : ST_OPCODE;
        end
        ST_PARAM_B: begin
          state <= ST_OPCODE;
        end
        // Spare code: drop back to waiting for an opcode
        default: begin
          state <= ST_OPCODE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Execute strobe: fires on the byte that completes a command
  // ----------------------------------------------------------------
  logic       exec;
  logic [7:0] exec_op;
  logic [7:0] p1;
  logic [7:0] p2;

  always_comb begin
    exec    = 1'b0;
    exec_op = held_op;
    p1      = cmd_byte;
    p2      = cmd_byte;
    unique case (state)
      ST_OPCODE: begin
        exec    = cmd_valid && !takes_param(cmd_byte);
        exec_op = cmd_byte;
      end
      ST_PARAM_A: begin
        exec = cmd_valid && !takes_two(held_op);
      end
      ST_PARAM_B: begin
        exec = cmd_valid;
        p1   = param_a;
      end
      // Spare code never applies a byte
      default: begin
        exec = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      CFG <= CFG_RESET;
    end else if (exec) begin
      unique case (exec_op) inside
        [8'h00:8'h0F]: begin
          CFG.page_col[3:0] <= exec_op[3:0];
        end
        [8'h10:8'h17]: begin
          CFG.page_col[6:4] <= exec_op[2:0];
        end
        OP_ADDR_MODE: begin
          if (p1[1:0] != MODE_INVALID) begin
            CFG.addr_mode <= p1[1:0];
          end
        end
        OP_COL_WIN: begin
          CFG.col_start <= p1[6:0];
          CFG.col_end   <= p2[6:0];
        end
        OP_PAGE_WIN: begin
          CFG.page_start <= p1[2:0];
          CFG.page_end   <= p2[2:0];
        end
        [8'h40:8'h7F]: begin
          CFG.start_line <= exec_op[5:0];
        end
        OP_CONTRAST: begin
          if (p1 >= CONTRAST_MIN) begin
            CFG.contrast <= p1;
          end
        end
        8'hA0, 8'hA1: begin
          CFG.col_mirror <= exec_op[0];
        end
        8'hA4, 8'hA5: begin
          CFG.entire_on <= exec_op[0];
        end
        8'hA6, 8'hA7: begin
          CFG.inverse <= exec_op[0];
        end
        OP_RATIO: begin
          if (p1[5:0] >= RATIO_MIN) begin
            CFG.multiplex_ratio <= p1[5:0];
          end
        end
        OP_IREF: begin
          CFG.iref_internal <= p1[4];
          CFG.iref_high     <= p1[5];
        end
        8'hAE, 8'hAF: begin
          CFG.display_on <= exec_op[0];
        end
        [8'hB0:8'hB7]: begin
          CFG.page_sel <= exec_op[2:0];
        end
        8'hC0, 8'hC8: begin
          CFG.row_scan_down <= exec_op[3];
        end
        OP_OFFSET: begin
          CFG.row_offset <= p1[5:0];
        end
        OP_CLOCK: begin
          CFG.clock_divide         <= p1[3:0];
          CFG.oscillator_frequency <= p1[7:4];
        end
        OP_PRECHARGE: begin
          // Each nibble judged alone, so a bad one spares the other
          if (p1[3:0] != 4'h0) begin
            CFG.phase1 <= p1[3:0];
          end
          if (p1[7:4] != 4'h0) begin
            CFG.phase2 <= p1[7:4];
          end
        end
        OP_ROW_PINS: begin
          CFG.alt_row_pins <= p1[4];
          CFG.row_lr_remap <= p1[5];
        end
        OP_DESELECT: begin
          CFG.deselect_level <= p1[5:4];
        end
        OP_NO_OP: begin
          // Accepted, nothing to change
        end
        default: begin
          // Unsupported opcodes are dropped as single bytes
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] read_word;

  always_comb begin
    read_word = 32'h0000_0000;
    if (mapped) begin
      unique case (offset)
        // One field a line, unused bits stay zero from the top
        OFS_CMD: begin
          read_word[7:0]   = held_op;
          read_word[15:8]  = param_a;
          read_word[17:16] = state;
        end
        OFS_ADDRESSING: begin
          read_word[1:0]   = CFG.addr_mode;
          read_word[14:8]  = CFG.page_col;
          read_word[18:16] = CFG.page_sel;
          read_word[29:24] = CFG.start_line;
        end
        OFS_WINDOW: begin
          read_word[6:0]   = CFG.col_start;
          read_word[14:8]  = CFG.col_end;
          read_word[18:16] = CFG.page_start;
          read_word[26:24] = CFG.page_end;
        end
        OFS_DISPLAY: begin
          read_word[7:0]   = CFG.contrast;
          read_word[8]     = CFG.col_mirror;
          read_word[9]     = CFG.entire_on;
          read_word[10]    = CFG.inverse;
          read_word[11]    = CFG.display_on;
          read_word[12]    = CFG.row_scan_down;
          read_word[13]    = CFG.alt_row_pins;
          read_word[14]    = CFG.row_lr_remap;
          read_word[15]    = CFG.iref_internal;
          read_word[16]    = CFG.iref_high;
          read_word[21:20] = CFG.deselect_level;
        end
        OFS_TIMING: begin
          read_word[5:0]   = CFG.multiplex_ratio;
          read_word[13:8]  = CFG.row_offset;
          read_word[19:16] = CFG.clock_divide;
          read_word[23:20] = CFG.oscillator_frequency;
          read_word[27:24] = CFG.phase1;
          read_word[31:28] = CFG.phase2;
        end
        default: begin
          read_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // Registered so the data is steady for the whole access phase
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= read_word;
    end
  end

endmodule // oled_command_decoder

//--- testbench/oled_cmd_properties.sv
// Port assertions for the display command decoder
`timescale 1ns/1ps
module oled_cmd_properties
  import oled_cmd_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Configuration
  input wire cfg_s        CFG
);
  logic [1:0] pend;
  logic [7:0] op;
  logic       wr;
  logic [7:0] b;
  logic       idle;
  assign wr   = PSEL && PENABLE && PWRITE && PADDR == 32'h0 && PSTRB[0];
  assign b    = PWDATA[7:0];
  assign idle = pend == 2'h0;
  // Owed parameter bytes, so opcode checks never fire on a parameter
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) pend <= 2'h0;
    else if (wr && !idle) pend <= pend - 2'h1;
    else if (wr && (b == OP_COL_WIN || b == OP_PAGE_WIN)) pend <= 2'h2;
    else if (wr) pend <= (b inside {8'h20, 8'h81, 8'hA8, 8'hAD, 8'hD3, 8'hD5, 8'hD9, 8'hDA, 8'hDB}) ? 2'h1 : 2'h0;
  end
  always_ff @(posedge CLK_SYS) begin
    if (wr && idle) op <= b;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  col_low_a: assert property (wr && idle && b[7:4] == 4'h0 |=> CFG.page_col[3:0] == $past(b[3:0]))
    else $error("page column low bits wrong");
  col_high_a: assert property (wr && idle && b[7:3] == 5'h02 |=> CFG.page_col[6:4] == $past(b[2:0]))
    else $error("page column high bits wrong");
  start_line_a: assert property (wr && idle && b[7:6] == 2'h1 |=> CFG.start_line == $past(b[5:0]))
    else $error("start line wrong");
  page_select_a: assert property (wr && idle && b[7:3] == 5'h16 |=> CFG.page_sel == $past(b[2:0]))
    else $error("page select wrong");
  display_power_a: assert property (wr && idle && b[7:1] == 7'h57 |=> CFG.display_on == $past(b[0]))
    else $error("display on state wrong");
  no_op_a: assert property (wr && idle && b == OP_NO_OP |=> $stable(CFG))
    else $error("no-operation changed state");
  param_wait_a: assert property (wr && pend == 2'h2 |=> $stable(CFG))
    else $error("setting applied before last byte");
  contrast_keep_a: assert property (wr && pend == 2'h1 && op == OP_CONTRAST && b == 8'h00 |=> $stable(CFG.contrast))
    else $error("zero contrast accepted");
  reset_cfg_a: assert property (disable iff (1'b0) !RESETN |=> CFG == CFG_RESET)
    else $error("reset values wrong");
endmodule // oled_cmd_properties

//--- testbench/oled_host_model.sv
// Host model issuing APB transfers toward the decoder
`timescale 1ns/1ps
module oled_host_model (
  // Clock
  input  wire logic        clk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    pstrb   = 4'hF;
  end
  // Request held until pready is seen at a rising edge, giving up after 20 edges
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic e, to);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    to = 1'b1;
    for (int i = 0; i < 20 && to; i++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        to = 1'b0;
        r  = prdata;
        e  = pslverr;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data must not look like the last value
    pwdata  <= ~d;
  endtask
endmodule // oled_host_model

//--- testbench/oled_fundamental_command_decoder_tb_top.sv
// Self-checking bench for the display command decoder
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module oled_fundamental_command_decoder_tb_top import oled_cmd_pkg::*; ;
  logic        CLK_SYS;
  logic        RESETN;
  logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [31:0] PADDR, PWDATA, PRDATA;
  logic [3:0]  PSTRB;
  cfg_s        CFG;
  cfg_s        exp, keep;
  logic [31:0] rdat;
  logic        err, to;
  int          bad_count, checks_done;
  oled_command_decoder dut_u (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CFG(CFG));
  oled_host_model host_u (.clk(CLK_SYS), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .pstrb(PSTRB), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    host_u.xfer(w, a, d, rdat, err, to);
    if (to) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic seq(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) bus(1'b1, 32'(OFS_CMD), {24'h0, v[8*i +: 8]});
  endtask
  task automatic check_cfg();
    @(negedge CLK_SYS);
    `CHK("cfg", exp, CFG)
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    RESETN = 1'b0;
    bad_count = 0;
    checks_done = 0;
    exp = CFG_RESET;
    repeat (3) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    check_cfg();
    bus(1'b0, 32'(OFS_DISPLAY), 32'h0);
    `CHK("display reg", 32'h0020207F, rdat)
    bus(1'b0, 32'h14, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    for (int m = 0; m < 3; m++) begin
      seq({16'h0020, 6'h00, 2'(m)}, 2);
      exp.addr_mode = 2'(m);
      check_cfg();
    end
    seq(24'h2003, 2);
    seq(24'h8100, 2);
    seq(24'hA80E, 2);
    check_cfg();
    seq(24'h210A, 2);
    check_cfg();
    seq(24'h70, 1);
    seq(24'h220205, 3);
    seq(24'h05137F, 3);
    seq(24'hB6, 1);
    exp.col_start = 7'h0A;
    exp.col_end = 7'h70;
    exp.page_start = 3'h2;
    exp.page_end = 3'h5;
    exp.page_col = 7'h35;
    exp.start_line = 6'h3F;
    exp.page_sel = 3'h6;
    check_cfg();
    keep = exp;
    seq(24'hA1A5A7, 3);
    seq(24'hAFC8, 2);
    {exp.col_mirror, exp.entire_on, exp.inverse, exp.display_on, exp.row_scan_down} = 5'h1F;
    check_cfg();
    seq(24'hA0A4A6, 3);
    seq(24'hAEC0E3, 3);
    exp = keep;
    check_cfg();
    seq(24'h81FF, 2);
    seq(24'hA80F, 2);
    seq(24'hAD30, 2);
    seq(24'hD32A, 2);
    seq(24'hD5F3, 2);
    seq(24'hD905, 2);
    seq(24'hDA20, 2);
    seq(24'hDB30, 2);
    exp.contrast = 8'hFF;
    exp.multiplex_ratio = 6'h0F;
    {exp.iref_high, exp.iref_internal} = 2'h3;
    exp.row_offset = 6'h2A;
    exp.clock_divide = 4'h3;
    exp.oscillator_frequency = 4'hF;
    exp.phase1 = 4'h5;
    {exp.row_lr_remap, exp.alt_row_pins} = 2'h2;
    exp.deselect_level = 2'h3;
    check_cfg();
    bus(1'b0, 32'(OFS_TIMING), 32'h0);
    `CHK("timing reg", 32'h25F32A0F, rdat)
    seq(24'h81, 1);
    // Opcode held, last parameter byte kept, waiting for one more byte
    bus(1'b0, 32'(OFS_CMD), 32'h0);
    `CHK("held opcode", 32'h00013081, rdat)
    @(posedge CLK_SYS);
    RESETN <= 1'b0;
    @(posedge CLK_SYS);
    RESETN <= 1'b1;
    exp = CFG_RESET;
    check_cfg();
    // A pending contrast opcode must not swallow this byte
    seq(24'hA1, 1);
    exp.col_mirror = 1'b1;
    check_cfg();
    test_done();
  end
endmodule // oled_fundamental_command_decoder_tb_top
bind oled_command_decoder oled_cmd_properties props_u (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CFG(CFG));
